// ### an_map_pkg.sv
// Package: register map, field positions, reset values and timing counts
package an_map_pkg;

	// ==========================================================
	// Register offsets (register number times four)
	localparam logic [7:0] CTRL_OFF       = 8'h00; // Control
	localparam logic [7:0] STAT_OFF       = 8'h04; // Status
	localparam logic [7:0] ADV_OFF        = 8'h10; // Advertisement
	localparam logic [7:0] LP_BASE_OFF    = 8'h14; // Partner base page
	localparam logic [7:0] EXP_OFF        = 8'h18; // Expansion
	localparam logic [7:0] NP_TX_OFF      = 8'h1c; // Next page transmit
	localparam logic [7:0] LP_NP_OFF      = 8'h20; // Partner next page
	localparam logic [7:0] RXCFG_OFF      = 8'h40; // Receive word feed
	localparam logic [7:0] TXCFG_OFF      = 8'h44; // Transmit word view

	// ==========================================================
	// Field positions
	localparam int CTRL_RESET_BIT    = 15;
	localparam int CTRL_LOOP_BIT     = 14;
	localparam int CTRL_ENABLE_BIT   = 12;
	localparam int CTRL_LOWPWR_BIT   = 11;
	localparam int CTRL_RESTART_BIT  = 9;
	localparam int STAT_DONE_BIT     = 5;
	localparam int STAT_LINK_BIT     = 2;
	localparam int EXP_NP_ABLE_BIT   = 2;
	localparam int EXP_PAGE_RX_BIT   = 1;
	localparam int CFG_NP_BIT        = 15;
	localparam int CFG_ACK_BIT       = 14;
	localparam int RXCFG_VALID_BIT   = 16;
	localparam int RXCFG_IDLE_BIT    = 17;
	localparam int RXCFG_SYNC_BIT    = 18;

	// ==========================================================
	// Reset values
	localparam logic [15:0] CTRL_RESET_VAL = 16'h1000;
	localparam logic [15:0] ADV_RESET_VAL  = 16'h0020;
	localparam logic [15:0] NP_RESET_VAL   = 16'h0000;

	// ==========================================================
	// Timing
	localparam int CLK_MHZ        = 100;
	localparam int LINK_TIMER_MS  = 10;
	localparam int LINK_TIMER_CYC = LINK_TIMER_MS * 1000 * CLK_MHZ;
	localparam int MATCH_COUNT    = 3;

endpackage

// ### link_timer.sv
// Link timer: counts a fixed period after a start pulse
`timescale 1ns/100ps
module link_timer #(
	parameter int CYCLES = an_map_pkg::LINK_TIMER_CYC
) (
	input  wire logic hclk,
	input  wire logic hresetn,
	input  wire logic start,
	output logic      done
);
	logic [31:0] count_reg; // Cycles remaining
	logic        run_reg;   // Timer running

	// ==========================================================
	// Counter
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			count_reg <= 32'h0;
			run_reg   <= 1'b0;
			done      <= 1'b0;
		end else if (start) begin
			count_reg <= 32'(CYCLES - 1);
			run_reg   <= 1'b1;
			done      <= 1'b0;
		end else if (run_reg && count_reg == 32'h0) begin
			run_reg <= 1'b0;
			done    <= 1'b1; // Held until next start
		end else if (run_reg) begin
			count_reg <= count_reg - 32'h1;
		end
	end
endmodule // link_timer

// ### match_detect.sv
// Match detector: three consecutive equal words, with ack view
`timescale 1ns/100ps
module match_detect (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        clear,
	input  wire logic        word_valid,
	input  wire logic        idle_seen,
	input  wire logic [15:0] word,
	output logic             ability_match,
	output logic             ack_match,
	output logic             idle_match,
	output logic [15:0]      match_word
);
	logic [1:0] count_reg;  // Matching words seen
	logic [1:0] idle_reg;   // Idle sets seen
	logic [15:0] ref_reg;   // Word for which count was one
	logic ack_all_reg;      // Every word of the run had ack
	wire  same = (word[15] == ref_reg[15]) && (word[13:0] == ref_reg[13:0]);

	// ==========================================================
	// Count matching words, clear on idle, restart at one on mismatch
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			count_reg   <= 2'h0;
			idle_reg    <= 2'h0;
			ref_reg     <= 16'h0;
			ack_all_reg <= 1'b0;
		end else if (clear) begin
			count_reg <= 2'h0;
			idle_reg  <= 2'h0;
		end else if (idle_seen) begin
			count_reg <= 2'h0;
			if (idle_reg != 2'h3)
				idle_reg <= idle_reg + 2'h1;
		end else if (word_valid) begin
			idle_reg <= 2'h0;
			if (count_reg == 2'h0 || !same) begin
				count_reg   <= 2'h1;
				ref_reg     <= word;
				ack_all_reg <= word[14];
			end else begin
				if (count_reg != 2'h3)
					count_reg <= count_reg + 2'h1;
				ack_all_reg <= ack_all_reg & word[14] &
					(word[14] == ref_reg[14]);
			end
		end
	end

	assign ability_match = (count_reg == 2'(an_map_pkg::MATCH_COUNT));
	assign ack_match     = ability_match && ack_all_reg;
	assign idle_match    = (idle_reg == 2'h3);
	assign match_word    = ref_reg;
endmodule // match_detect

// ### autoneg_mgmt_variable_map.sv
// Auto-negotiation management variables behind an AHB-Lite slave
//
// Functional notes
// - Advertisement register feeds transmitted base page
// - Status bit 5 shows negotiation done
// - Control bit 12 enables negotiation
// - Control bit 15 resets negotiation function
// - Control bit 9 restarts negotiation
// - Received base page stored in partner register
// - Received next page stored in partner register
// - Expansion bit 2 shows next page capability
// - Next page write sets loaded flag
// - Next page register sent during exchange
// - Page received after ack and consistency
// - Fixed advertisement used without management
// - Defaulted variables revert when not assigned
// - Sync fail reported after link timer
// - Partner more-pages bit latched at complete-ack
// - Low power bit forces power-on condition
// - Priority resolve only in explicit states
// - Link timer lasts ten milliseconds
// - Ability match after three equal words
// - Expansion read clears page received
//
// Design decisions made here: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/100ps
module autoneg_mgmt_variable_map #(
	parameter int          LINK_CYCLES = an_map_pkg::LINK_TIMER_CYC,
	parameter logic        NP_SUPPORT  = 1'b1,
	parameter logic        HAS_MGMT    = 1'b1,
	parameter logic [15:0] FIXED_ADV   = an_map_pkg::ADV_RESET_VAL
) (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic [31:0]      hrdata,
	output logic             hreadyout,
	output logic             hresp,
	output logic [15:0]      tx_config_word,
	output logic [1:0]       xmit_mode,
	output logic             loop_back_ctl,
	output logic             priority_resolve
);
	// ==========================================================
	// State encoding
	typedef enum logic [6:0] {
		ST_ENABLE   = 7'h01,
		ST_RESTART  = 7'h02,
		ST_ABILITY  = 7'h04,
		ST_ACK_DET  = 7'h08,
		ST_CMPL_ACK = 7'h10,
		ST_IDLE_DET = 7'h20,
		ST_LINK_OK  = 7'h40
	} an_state_t;

	localparam logic [1:0] XMIT_IDLE = 2'h0; // Idle sets
	localparam logic [1:0] XMIT_CFG  = 2'h1; // Configuration words
	localparam logic [1:0] XMIT_DATA = 2'h2; // Data path

	// ==========================================================
	// Registers
	logic [15:0] ctrl_reg;         // Control bits
	logic [15:0] adv_reg;          // Local advertised page
	logic [15:0] tx_next_page;     // Next page to send
	logic [15:0] partner_base_page; // Partner base page
	logic [15:0] partner_next_page; // Partner next page
	logic        page_received_flag;
	logic        tx_next_page_loaded;
	logic        negotiation_done_flag;
	logic        latched_partner_more_pages;
	logic        base_done_reg;    // Base page already taken
	logic        np_send_reg;      // Next page on the wire
	logic [15:0] ack_word_reg;     // Word seen at ack match
	logic [15:0] abil_word_reg;    // Word seen at ability match
	logic [18:0] rx_raw_reg;       // Receive feed, written by bus
	logic        rx_strobe_reg;    // One-cycle feed strobe
	logic        enable_d_reg;     // Previous enable value
	logic        bad_sync_reg;     // Qualified sync failed
	an_state_t   state_reg;
	an_state_t   state_next;

	// Bus pipeline
	logic        dp_wr_reg;
	logic [7:0]  dp_addr_reg;

	// ==========================================================
	// Address phase and data phase decode
	wire        addr_ok   = hsel && hready && htrans[1];
	wire        wr_now    = dp_wr_reg;
	wire [15:0] wdata     = hwdata[15:0];
	wire        wr_ctrl   = wr_now && dp_addr_reg == an_map_pkg::CTRL_OFF;
	wire        wr_adv    = wr_now && dp_addr_reg == an_map_pkg::ADV_OFF;
	wire        wr_np     = wr_now && dp_addr_reg == an_map_pkg::NP_TX_OFF;
	wire        wr_rxcfg  = wr_now && dp_addr_reg == an_map_pkg::RXCFG_OFF;
	wire        rd_exp    = addr_ok && !hwrite &&
		haddr[7:0] == an_map_pkg::EXP_OFF;

	// ==========================================================
	// Control decode
	wire an_reset   = ctrl_reg[an_map_pkg::CTRL_RESET_BIT];
	wire an_enable  = ctrl_reg[an_map_pkg::CTRL_ENABLE_BIT];
	wire an_restart = ctrl_reg[an_map_pkg::CTRL_RESTART_BIT];
	wire power_on   = ctrl_reg[an_map_pkg::CTRL_LOWPWR_BIT];
	wire enable_chg = an_enable != enable_d_reg;
	wire [15:0] adv_src = HAS_MGMT ? adv_reg : FIXED_ADV;
	wire fsm_reset = an_reset || power_on || an_restart ||
		enable_chg || bad_sync_reg;

	// Receive feed fields
	wire [15:0] rx_word  = rx_raw_reg[15:0];
	wire rx_valid = rx_strobe_reg && rx_raw_reg[an_map_pkg::RXCFG_VALID_BIT];
	wire rx_idle  = rx_strobe_reg && rx_raw_reg[an_map_pkg::RXCFG_IDLE_BIT];
	wire sync_ok  = rx_raw_reg[an_map_pkg::RXCFG_SYNC_BIT];

	// ==========================================================
	// Matchers and timers
	wire ability_match;
	wire ack_match;
	wire idle_match;
	wire [15:0] match_word;
	wire state_change = state_next != state_reg;
	wire lt_done;
	wire sync_lt_done;
	logic sync_start;

	match_detect u_match (
		.hclk          (hclk),
		.hresetn       (hresetn),
		.clear         (state_change),
		.word_valid    (rx_valid),
		.idle_seen     (rx_idle),
		.word          (rx_word),
		.ability_match (ability_match),
		.ack_match     (ack_match),
		.idle_match    (idle_match),
		.match_word    (match_word)
	);

	link_timer #(.CYCLES(LINK_CYCLES)) u_state_timer (
		.hclk    (hclk),
		.hresetn (hresetn),
		.start   (state_change || fsm_reset),
		.done    (lt_done)
	);

	link_timer #(.CYCLES(LINK_CYCLES)) u_sync_timer (
		.hclk    (hclk),
		.hresetn (hresetn),
		.start   (sync_start),
		.done    (sync_lt_done)
	);

	// Consistency: ack word equals ability word, ack bit ignored
	wire consistent = (match_word[15] == abil_word_reg[15]) &&
		(match_word[13:0] == abil_word_reg[13:0]);
	wire page_ok = ack_match && consistent;
	wire np_exch = base_done_reg && adv_src[an_map_pkg::CFG_NP_BIT] &&
		partner_base_page[an_map_pkg::CFG_NP_BIT];

	// ==========================================================
	// Next state
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_ENABLE:   state_next = an_enable ? ST_RESTART : ST_LINK_OK;
			ST_RESTART:  if (lt_done) state_next = ST_ABILITY;
			ST_ABILITY:  if (ability_match && match_word != 16'h0)
				state_next = ST_ACK_DET;
			ST_ACK_DET: begin
				if (page_ok)
					state_next = ST_CMPL_ACK;
				else if (ack_match)
					state_next = ST_ENABLE;
			end
			ST_CMPL_ACK: begin
				if (lt_done && (!np_exch ||
					(!tx_next_page[an_map_pkg::CFG_NP_BIT] &&
					 !latched_partner_more_pages)))
					state_next = ST_IDLE_DET;
				else if (lt_done && np_exch && tx_next_page_loaded)
					state_next = ST_ABILITY;
			end
			ST_IDLE_DET: if (lt_done && idle_match) state_next = ST_LINK_OK;
			ST_LINK_OK:  if (ability_match) state_next = ST_ENABLE;
			default:     state_next = ST_ENABLE;
		endcase
		if (fsm_reset)
			state_next = ST_ENABLE;
	end

	// Defaulted variables depend on state only
	wire resolve_now = (state_next == ST_IDLE_DET);
	// Base page stays on the wire until its complete-ack is left
	wire np_leave = state_reg == ST_CMPL_ACK && state_next == ST_ABILITY;
	wire np_sel   = np_send_reg || np_leave;
	wire [1:0] xmit_now = (state_next == ST_LINK_OK) ? XMIT_DATA :
		(state_next == ST_IDLE_DET) ? XMIT_IDLE : XMIT_CFG;
	wire [15:0] tx_now = (state_next == ST_ABILITY ||
		state_next == ST_ACK_DET || state_next == ST_CMPL_ACK) ?
		((np_sel ? tx_next_page : adv_src) |
		 ((state_next != ST_ABILITY) ? 16'h4000 : 16'h0)) : 16'h0;

	// ==========================================================
	// State register and outputs
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg        <= ST_ENABLE;
			tx_config_word   <= 16'h0;
			xmit_mode        <= XMIT_CFG;
			priority_resolve <= 1'b0;
			loop_back_ctl    <= 1'b0;
		end else begin
			state_reg        <= state_next;
			tx_config_word   <= tx_now;
			xmit_mode        <= xmit_now;
			priority_resolve <= resolve_now;
			loop_back_ctl    <= ctrl_reg[an_map_pkg::CTRL_LOOP_BIT];
		end
	end

	// ==========================================================
	// Page capture and flags
	wire take_page = state_reg == ST_ACK_DET && state_next == ST_CMPL_ACK;
	wire [15:0] ack_word = ack_match ? match_word : ack_word_reg; // Last ack
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			partner_base_page          <= 16'h0;
			partner_next_page          <= 16'h0;
			page_received_flag         <= 1'b0;
			latched_partner_more_pages <= 1'b0;
			base_done_reg              <= 1'b0;
			np_send_reg                <= 1'b0;
			abil_word_reg              <= 16'h0;
			ack_word_reg               <= 16'h0;
			negotiation_done_flag      <= 1'b0;
		end else begin
			if (state_next == ST_ACK_DET && state_reg != ST_ACK_DET)
				abil_word_reg <= match_word;
			if (ack_match)
				ack_word_reg <= match_word;
			if (take_page) begin
				if (!base_done_reg)
					partner_base_page <= match_word;
				else
					partner_next_page <= match_word;
				base_done_reg <= 1'b1;
				latched_partner_more_pages <=
					ack_word[an_map_pkg::CFG_NP_BIT];
			end
			// Set wins over read clear
			if (take_page)
				page_received_flag <= 1'b1;
			else if (rd_exp || fsm_reset)
				page_received_flag <= 1'b0;
			if (state_next == ST_ENABLE)
				base_done_reg <= 1'b0;
			// Next page source held until negotiation starts over
			if (np_leave)
				np_send_reg <= 1'b1;
			else if (state_next == ST_ENABLE)
				np_send_reg <= 1'b0;
			negotiation_done_flag <= (state_next == ST_LINK_OK) &&
				an_enable;
		end
	end

	// ==========================================================
	// Qualified sync
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sync_start   <= 1'b0;
			bad_sync_reg <= 1'b0;
			enable_d_reg <= 1'b1;
		end else begin
			sync_start   <= sync_ok;
			bad_sync_reg <= !sync_ok && sync_lt_done;
			enable_d_reg <= an_enable;
		end
	end

	// ==========================================================
	// Software registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_reg            <= an_map_pkg::CTRL_RESET_VAL;
			adv_reg             <= an_map_pkg::ADV_RESET_VAL;
			tx_next_page        <= an_map_pkg::NP_RESET_VAL;
			tx_next_page_loaded <= 1'b0;
			rx_raw_reg          <= 19'h0;
			rx_strobe_reg       <= 1'b0;
		end else begin
			rx_strobe_reg <= wr_rxcfg;
			if (wr_rxcfg)
				rx_raw_reg <= hwdata[18:0];
			if (wr_ctrl)
				ctrl_reg <= wdata;
			else if (ctrl_reg[an_map_pkg::CTRL_RESET_BIT] ||
				ctrl_reg[an_map_pkg::CTRL_RESTART_BIT])
				ctrl_reg <= ctrl_reg & 16'h7dff; // Self-clearing
			if (wr_adv)
				adv_reg <= wdata & 16'hb1e0;
			if (wr_np)
				tx_next_page <= wdata;
			// Write sets, only the state machine clears
			if (wr_np)
				tx_next_page_loaded <= 1'b1;
			else if (take_page || state_next == ST_ENABLE)
				tx_next_page_loaded <= 1'b0;
		end
	end

	// ==========================================================
	// Read mux
	logic [15:0] rd_mux;
	always_comb begin
		case (haddr[7:0])
			an_map_pkg::CTRL_OFF:    rd_mux = ctrl_reg;
			an_map_pkg::STAT_OFF:    rd_mux = {10'h0,
				negotiation_done_flag, 2'h0,
				xmit_mode == XMIT_DATA, 2'h0};
			an_map_pkg::ADV_OFF:     rd_mux = adv_src;
			an_map_pkg::LP_BASE_OFF: rd_mux = partner_base_page;
			an_map_pkg::EXP_OFF:     rd_mux = {13'h0, NP_SUPPORT,
				page_received_flag, 1'b0};
			an_map_pkg::NP_TX_OFF:   rd_mux = tx_next_page;
			an_map_pkg::LP_NP_OFF:   rd_mux = partner_next_page;
			an_map_pkg::TXCFG_OFF:   rd_mux = tx_config_word;
			default:                 rd_mux = 16'h0;
		endcase
	end

	// ==========================================================
	// Bus pipeline: zero wait states
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_wr_reg   <= 1'b0;
			dp_addr_reg <= 8'h0;
			hrdata      <= 32'h0;
			hreadyout   <= 1'b1;
			hresp       <= 1'b0;
		end else begin
			dp_wr_reg   <= addr_ok && hwrite;
			dp_addr_reg <= haddr[7:0];
			hrdata      <= (addr_ok && !hwrite) ? {16'h0, rd_mux} : 32'h0;
			hreadyout   <= 1'b1;
			hresp       <= 1'b0;
		end
	end
endmodule // autoneg_mgmt_variable_map

// ### autoneg_mgmt_variable_map_chk.sv
// Checker: bus answers and control-to-port relations of the variable map
`timescale 1ns/100ps
module an_map_chk #(
	parameter logic NP_SUPPORT = 1'b1
) (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	input  wire logic [31:0] hrdata,
	input  wire logic        hreadyout,
	input  wire logic        hresp,
	input  wire logic [15:0] tx_config_word,
	input  wire logic [1:0]  xmit_mode,
	input  wire logic        loop_back_ctl,
	input  wire logic        priority_resolve
);
	// ==========================================================
	// Data phase tracking
	logic        wr_ph;   // Write data phase
	logic        rd_ph;   // Read data phase
	logic [31:0] ph_addr; // Address of the phase
	logic        lb_val;  // Loop bit of last control write
	wire         take;    // Address phase accepted
	wire         mapped;  // Phase address decodes
	assign take   = hsel & hready & htrans[1];
	assign mapped = (ph_addr[31:8] == 24'h0) && (ph_addr[7:0] inside
		{8'h00, 8'h04, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h40, 8'h44});
	// Phase registers and captured loop bit
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_ph   <= 1'b0;
			rd_ph   <= 1'b0;
			ph_addr <= 32'h0;
			lb_val  <= 1'b0;
		end else begin
			wr_ph <= take & hwrite;
			rd_ph <= take & ~hwrite;
			if (take) begin
				ph_addr <= haddr;
			end
			if (wr_ph && ph_addr == 32'h0) begin
				lb_val <= hwdata[an_map_pkg::CTRL_LOOP_BIT];
			end
		end
	end
	// ==========================================================
	// Assertions
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence ctrl_wr_s;
		wr_ph && ph_addr == 32'h0;
	endsequence
	sequence rd_s;
		rd_ph;
	endsequence
	no_wait_a: assert property (hreadyout)
		else $error("slave inserted a wait state");
	okay_resp_a: assert property (!hresp)
		else $error("slave gave an error response");
	loop_follow_a: assert property (
		ctrl_wr_s |-> ##[1:2] (loop_back_ctl == lb_val))
		else $error("loop output did not follow control write");
	mode_legal_a: assert property (xmit_mode != 2'b11)
		else $error("transmit source took an unused code");
	prio_idle_a: assert property (
		$rose(priority_resolve) |-> ##[0:1] (xmit_mode == 2'b00))
		else $error("priority resolve outside idle detect");
	upper_zero_a: assert property (
		rd_s |-> hrdata[31:16] == 16'h0)
		else $error("read data upper half not zero");
	unmapped_zero_a: assert property (
		rd_s ##0 !mapped |-> hrdata == 32'h0)
		else $error("unmapped read returned data");
	np_able_a: assert property (
		rd_s ##0 (ph_addr == 32'h18) |->
		((hrdata[15:0] & 16'hfffd) == {13'h0, NP_SUPPORT, 2'b00}))
		else $error("expansion capability bits wrong");
endmodule // an_map_chk

bind autoneg_mgmt_variable_map an_map_chk #(.NP_SUPPORT(NP_SUPPORT))
	i_an_map_chk (
	.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
	.hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
	.hresp(hresp), .tx_config_word(tx_config_word),
	.xmit_mode(xmit_mode), .loop_back_ctl(loop_back_ctl),
	.priority_resolve(priority_resolve)
);

// ### mgmt_master.sv
// Management entity model: AHB-Lite single word master
`timescale 1ns/100ps
module mgmt_master (
	input  wire logic        hclk,
	input  wire logic        hready,
	input  wire logic [31:0] hrdata,
	output logic             hsel,
	output logic [31:0]      haddr,
	output logic [1:0]       htrans,
	output logic             hwrite,
	output logic [2:0]       hsize,
	output logic [31:0]      hwdata
);
	// ==========================================================
	// Idle bus at time zero
	initial begin
		hsel   = 1'b0;
		haddr  = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize  = 3'b010;
		hwdata = 32'h0;
	end
	// One transfer, entered just after a rising edge
	task automatic xfer(input logic [7:0] a, input logic w,
		input logic [31:0] d, output logic [31:0] r);
		hsel   <= 1'b1;
		haddr  <= {24'h0, a};
		htrans <= 2'b10;
		hwrite <= w;
		hwdata <= ~hwdata; // Stale data scrambled
		do @(posedge hclk); while (hready !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'b00;
		haddr  <= ~haddr;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		r = hrdata;
	endtask
	// Next page load: partner page read before transmit page
	task automatic load_np(input logic [31:0] d, output logic [31:0] lp);
		logic [31:0] x;
		xfer(an_map_pkg::LP_NP_OFF, 1'b0, 32'h0, lp);
		xfer(an_map_pkg::NP_TX_OFF, 1'b1, d, x);
	endtask
endmodule // mgmt_master

// ### tb_autoneg_mgmt_variable_map.sv
// Testbench: register map and negotiation flow against a model
`timescale 1ns/100ps
module tb_autoneg_mgmt_variable_map;
	// ==========================================================
	// Signals and model state
	localparam int         LC = 20; // Short link timer
	localparam logic [7:0] CT = an_map_pkg::CTRL_OFF;
	localparam logic [7:0] ST = an_map_pkg::STAT_OFF;
	localparam logic [7:0] AD = an_map_pkg::ADV_OFF;
	localparam logic [7:0] LB = an_map_pkg::LP_BASE_OFF;
	localparam logic [7:0] EX = an_map_pkg::EXP_OFF;
	localparam logic [7:0] NT = an_map_pkg::NP_TX_OFF;
	localparam logic [7:0] LN = an_map_pkg::LP_NP_OFF;
	localparam logic [7:0] RX = an_map_pkg::RXCFG_OFF;
	logic        hclk;
	logic        hresetn;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic [15:0] tx_config_word;
	logic [1:0]  xmit_mode;
	logic        loop_back_ctl;
	logic        priority_resolve;
	int          mismatches;
	int          cmp_count;
	logic        prio_seen;          // Priority resolve seen high
	logic [31:0] mdl [logic [7:0]];  // Expected register words
	logic [7:0]  offs [8] = '{CT, ST, AD, LB, EX, NT, LN, 8'h08};
	logic [7:0]  ro [4]   = '{ST, LB, EX, 8'h08}; // Writes ignored
	logic [31:0] w;                  // Partner base page
	logic [31:0] r;                  // Read result
	autoneg_mgmt_variable_map #(.LINK_CYCLES(LC)) i_autoneg_mgmt_variable_map (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .tx_config_word(tx_config_word),
		.xmit_mode(xmit_mode), .loop_back_ctl(loop_back_ctl),
		.priority_resolve(priority_resolve));
	mgmt_master i_mgmt_master (
		.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata));
	// Clock of 10 ns
	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end
	// Note any priority resolve pulse
	always @(posedge hclk) begin
		if (priority_resolve === 1'b1) begin
			prio_seen <= 1'b1;
		end
	end
	// ==========================================================
	// Tasks
	task automatic chk(input string n, input logic [31:0] e,
		input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask
	// Write and update the model with what the register keeps
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		i_mgmt_master.xfer(a, 1'b1, d, x);
		case (a)
			CT: mdl[a] = d & 32'h5800; // Self-clearing bits dropped
			AD: mdl[a] = d & 32'hb1e0;
			NT: mdl[a] = d & 32'hffff;
			default: ;
		endcase
	endtask
	// Read after a gap and compare with the model
	task automatic rdc(input logic [7:0] a);
		logic [31:0] x;
		repeat (2) @(posedge hclk);
		i_mgmt_master.xfer(a, 1'b0, 32'h0, x);
		chk($sformatf("register %h", a), mdl.exists(a) ? mdl[a] : 32'h0, x);
	endtask
	task automatic all_regs;
		foreach (offs[i]) begin
			rdc(offs[i]);
		end
	endtask
	// Received sets: k is sync, idle, valid
	task automatic feed(input logic [15:0] wd, input logic [2:0] k,
		input int n);
		repeat (n) wr(RX, {13'h0, k, wd});
	endtask
	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// Watchdog against a hang
	initial begin
		#200000;
		mismatches++;
		give_verdict();
	end
	// ==========================================================
	// Main sequence
	initial begin
		mismatches = 0;
		cmp_count  = 0;
		prio_seen  = 1'b0;
		mdl[CT]    = 32'h1000;
		mdl[AD]    = 32'h0020;
		mdl[EX]    = 32'h0004;
		void'($urandom(32'h3d202ef2));
		hresetn = 1'b0;
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		all_regs();
		feed(16'h0, 3'b100, 1);
		foreach (ro[i]) begin
			wr(ro[i], $urandom);
		end
		wr(AD, $urandom);
		w = $urandom;
		i_mgmt_master.load_np(w, r);
		mdl[NT] = w & 32'hffff;
		chk("partner next page", 32'h0, r);
		all_regs();
		wr(CT, 32'h1200);
		repeat (LC * 3) @(posedge hclk);
		#1;
		chk("tx word", mdl[AD], {16'h0, tx_config_word});
		chk("mode config", 32'h1, {30'h0, xmit_mode});
		rdc(CT);
		w = ($urandom & 32'h3fff) | 32'h0020;
		feed(w[15:0], 3'b101, 3);
		feed(w[15:0] | 16'h4000, 3'b101, 20);
		mdl[LB] = w | 32'h4000;
		mdl[EX] = 32'h0006;
		rdc(EX);
		mdl[EX] = 32'h0004;
		rdc(EX);
		rdc(LB);
		feed(16'h0, 3'b110, 30);
		#1;
		chk("mode data", 32'h2, {30'h0, xmit_mode});
		chk("priority seen", 32'h1, {31'h0, prio_seen});
		mdl[ST] = 32'h0024;
		rdc(ST);
		feed(16'h0, 3'b000, 20);
		#1;
		chk("mode after sync loss", 32'h1, {30'h0, xmit_mode});
		mdl[ST] = 32'h0;
		rdc(ST);
		feed(16'h0, 3'b100, 1);
		wr(CT, 32'h0);
		repeat (10) @(posedge hclk);
		#1;
		chk("mode disabled", 32'h2, {30'h0, xmit_mode});
		wr(CT, 32'h5000);
		repeat (3) @(posedge hclk);
		#1;
		chk("loop", 32'h1, {31'h0, loop_back_ctl});
		rdc(CT);
		wr(CT, 32'h9000);
		repeat (5) @(posedge hclk);
		#1;
		chk("mode after reset", 32'h1, {30'h0, xmit_mode});
		chk("loop after reset", 32'h0, {31'h0, loop_back_ctl});
		rdc(CT);
		// Next page exchange: both sides advertise more pages
		wr(AD, 32'h8020);
		repeat (LC * 2) @(posedge hclk);
		feed(16'h80a0, 3'b101, 3);
		feed(16'hc0a0, 3'b101, 3);
		i_mgmt_master.load_np(32'h0123, r);
		chk("partner next page empty", 32'h0, r);
		mdl[NT] = 32'h0123;
		mdl[LB] = 32'hc0a0;
		repeat (LC * 2) @(posedge hclk);
		#1;
		chk("tx next page", 32'h0123, {16'h0, tx_config_word});
		feed(16'h2abc, 3'b101, 3);
		feed(16'h6abc, 3'b101, 3);
		repeat (4) @(posedge hclk);
		#1;
		chk("tx next page ack", 32'h4123, {16'h0, tx_config_word});
		mdl[LN] = 32'h6abc;
		rdc(LN);
		rdc(LB);
		repeat (LC * 2) @(posedge hclk);
		#1;
		chk("mode after last page", 32'h0, {30'h0, xmit_mode});
		// Low power holds the negotiation at its start
		wr(CT, 32'h1800);
		repeat (5) @(posedge hclk);
		#1;
		chk("mode low power", 32'h1, {30'h0, xmit_mode});
		rdc(CT);
		give_verdict();
	end
endmodule // tb_autoneg_mgmt_variable_map
